// *** rtl/ts_serial_layer1.sv ***
// Serial transport-stream layer 1: comma framing, FIFOs, sync detector, Avalon-MM status.
`timescale 1ns/10ps
module ts_serial_layer1 #(
   parameter int TX_DEPTH = 256,
   parameter int RX_DEPTH = 256
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic clear_n_in,
   input wire logic freeze_in,
   input wire logic tx_clk_in,
   input wire logic [7:0] tx_din_in,
   input wire logic tx_psync_in,
   input wire logic tx_dvalid_in,
   output logic tx_ffull_out,
   output logic tx_fafull_out,
   output logic tx_faemp_out,
   input wire logic tx_full_clk_in,
   output logic [7:0] txdata_out,
   output logic tx_k_out,
   input wire logic rx_full_clk_in,
   input wire logic [7:0] rxdata_in,
   input wire logic rx_k_in,
   input wire logic rx_clk_in,
   output logic [7:0] rx_dout_out,
   output logic rx_dvalid_out,
   output logic rx_psync_out,
   output logic rx_ffull_out,
   output logic rx_fafull_out,
   output logic rx_faemp_out,
   output logic rx_sync_byte_out,
   output logic rx_pkt_size_out,
   output logic rx_locked_out,
   output logic rx_runt_out,
   output logic rx_giant_out,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   localparam int TXA = $clog2(TX_DEPTH);
   localparam int RXA = $clog2(RX_DEPTH);
   localparam int PW = 24;

   // Merges one written word into a stored word under the byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // True once a counter has reached its threshold, so one more step goes past it.
   function automatic logic past_thr(input logic [7:0] cnt, input logic [7:0] thr);
      return cnt >= thr;
   endfunction

   logic kill_r; // Internal reset, raised at once by the pin and on the edge by rst_in.
   logic [PW-1:0] pin_s1_r; // First synchroniser stage of every foreign input.
   logic [PW-1:0] pin_s2_r; // Second stage, the first one logic may read.
   logic [3:0] clk_prev_r; // Previous synchronised level of the four foreign clocks.
   logic [31:0] detect_cfg_r; // Match, unlock and hunt thresholds.
   logic [31:0] tx_levels_r; // Transmit almost-full and almost-empty levels.
   logic [31:0] rx_levels_r; // Receive almost-full and almost-empty levels.
   logic [8:0] tx_mem [TX_DEPTH]; // Transmit storage, packet-start flag on top.
   logic [8:0] rx_mem [RX_DEPTH]; // Receive storage, packet-start flag on top.
   logic [TXA:0] tx_wp_r; // Transmit write pointer.
   logic [TXA:0] tx_rp_r; // Transmit read pointer.
   logic [RXA:0] rx_wp_r; // Receive write pointer.
   logic [RXA:0] rx_rp_r; // Receive read pointer.
   logic [1:0] lead_r; // Commas already sent ahead of the waiting packet start.
   ts_serial_pkg::det_state_e det_r; // Sync detector state.
   logic [1:0] sel_r; // Candidate pairing: bit 0 sync byte, bit 1 packet size.
   logic [7:0] pos_r; // Byte position within the current packet.
   logic [7:0] slot_r; // Bytes since the last sync slot, seen or missed, while locked.
   logic [7:0] match_r; // Consecutive sync matches while tracking.
   logic [7:0] err_r; // Missed syncs while locked.
   logic [7:0] hunt_r; // Failed packets on the current pairing.
   logic runt_r; // Short packet seen.
   logic giant_r; // Long packet seen.
   logic ack_r; // Bus answer cycle.

   // Aliases of the synchronised inputs.
   logic frozen;
   logic tx_clk_s, tx_psync_s, tx_dvalid_s, txf_clk_s, rxf_clk_s, rx_k_s, rx_clk_s;
   logic [7:0] tx_din_s, rxdata_s;
   logic tx_edge, txf_edge, rxf_edge, rx_edge;
   logic [TXA:0] tx_cnt;
   logic [RXA:0] rx_cnt;
   logic tx_full, tx_empty, rx_full, rx_empty;
   logic [8:0] tx_head, rx_head;
   logic [7:0] sync_val, len_val;
   logic byte_ev, is_sync;
   logic bus_req;

   assign {tx_clk_s, tx_psync_s, tx_dvalid_s, tx_din_s} = pin_s2_r[10:0];
   assign {rxf_clk_s, rx_k_s, rxdata_s} = pin_s2_r[20:11];
   assign {txf_clk_s, rx_clk_s, frozen} = pin_s2_r[23:21];
   assign tx_edge = tx_clk_s && !clk_prev_r[0] && !frozen;
   assign txf_edge = txf_clk_s && !clk_prev_r[1] && !frozen;
   assign rxf_edge = rxf_clk_s && !clk_prev_r[2] && !frozen;
   assign rx_edge = rx_clk_s && !clk_prev_r[3] && !frozen;
   assign tx_cnt = tx_wp_r - tx_rp_r;
   assign rx_cnt = rx_wp_r - rx_rp_r;
   assign tx_full = tx_cnt == (TXA+1)'(TX_DEPTH);
   assign tx_empty = tx_cnt == '0;
   assign rx_full = rx_cnt == (RXA+1)'(RX_DEPTH);
   assign rx_empty = rx_cnt == '0;
   assign tx_head = tx_mem[tx_rp_r[TXA-1:0]];
   assign rx_head = rx_mem[rx_rp_r[RXA-1:0]];
   assign sync_val = sel_r[0] ? ts_serial_pkg::SYNC_INVERTED : ts_serial_pkg::SYNC_NORMAL;
   assign len_val = sel_r[1] ? ts_serial_pkg::LEN_LONG : ts_serial_pkg::LEN_SHORT;
   assign byte_ev = rxf_edge && !rx_k_s;
   assign is_sync = rxdata_s == sync_val;
   assign bus_req = (avs_read_in || avs_write_in) && !ack_r;

   // The pin raises the internal reset at once; rst_in raises it at the next edge.
   always_ff @(posedge clock_in or negedge clear_n_in) begin
      if (!clear_n_in) begin
         kill_r <= 1'b1;
      end else begin
         kill_r <= rst_in;
      end
   end

   // Two-stage synchroniser for every pin from another clock domain.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         clk_prev_r <= '0;
      end else begin
         pin_s1_r <= {tx_full_clk_in, rx_clk_in, freeze_in, rx_full_clk_in, rx_k_in, rxdata_in,
                      tx_clk_in, tx_psync_in, tx_dvalid_in, tx_din_in};
         pin_s2_r <= pin_s1_r;
         clk_prev_r <= {rx_clk_s, rxf_clk_s, txf_clk_s, tx_clk_s};
      end
   end

   // Transmit storage write; no reset is needed on the data array itself.
   always_ff @(posedge clock_in) begin
      if (tx_edge && tx_dvalid_s && !tx_full) begin
         tx_mem[tx_wp_r[TXA-1:0]] <= {tx_psync_s, tx_din_s};
      end
   end

   // Transmit write pointer: only valid bytes while room remains are taken.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         tx_wp_r <= '0;
      end else if (tx_edge && tx_dvalid_s && !tx_full) begin
         tx_wp_r <= tx_wp_r + 1'b1;
      end
   end

   // Serializer side: lead commas, payload, or filler commas on each line clock.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         tx_rp_r <= '0;
         lead_r <= '0;
         txdata_out <= ts_serial_pkg::COMMA_CHAR;
         tx_k_out <= 1'b1;
      end else if (txf_edge) begin
         if (!tx_empty && tx_head[8] && lead_r != ts_serial_pkg::LEAD_COMMAS) begin
            // A packet start waits: send the next of its two lead commas.
            lead_r <= lead_r + 1'b1;
            txdata_out <= ts_serial_pkg::COMMA_CHAR;
            tx_k_out <= 1'b1;
         end else if (!tx_empty) begin
            // Payload byte goes out unchanged.
            tx_rp_r <= tx_rp_r + 1'b1;
            lead_r <= '0;
            txdata_out <= tx_head[7:0];
            tx_k_out <= 1'b0;
         end else begin
            // Nothing waits: fill the line with a comma.
            txdata_out <= ts_serial_pkg::COMMA_CHAR;
            tx_k_out <= 1'b1;
         end
      end
   end

   // Receive storage write: comma bytes never enter.
   always_ff @(posedge clock_in) begin
      if (byte_ev && !rx_full) begin
         rx_mem[rx_wp_r[RXA-1:0]] <= {is_sync && det_r == ts_serial_pkg::DET_LOCK, rxdata_s};
      end
   end

   // Receive write pointer; bytes arriving while full are lost.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         rx_wp_r <= '0;
      end else if (byte_ev && !rx_full) begin
         rx_wp_r <= rx_wp_r + 1'b1;
      end
   end

   // User receive side: one byte per receive clock rise while data waits.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         rx_rp_r <= '0;
         rx_dout_out <= 8'h00;
         rx_dvalid_out <= 1'b0;
         rx_psync_out <= 1'b0;
      end else if (rx_edge) begin
         if (!rx_empty) begin
            rx_rp_r <= rx_rp_r + 1'b1;
            rx_dout_out <= rx_head[7:0];
            rx_dvalid_out <= 1'b1;
            rx_psync_out <= rx_head[8];
         end else begin
            rx_dvalid_out <= 1'b0;
            rx_psync_out <= 1'b0;
         end
      end
   end

   // Level flags, registered so the outputs come from flip-flops.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         tx_ffull_out <= 1'b0;
         tx_fafull_out <= 1'b0;
         tx_faemp_out <= 1'b1;
         rx_ffull_out <= 1'b0;
         rx_fafull_out <= 1'b0;
         rx_faemp_out <= 1'b1;
      end else begin
         tx_ffull_out <= tx_full;
         tx_fafull_out <= 12'(tx_cnt) >= tx_levels_r[ts_serial_pkg::LVL_AFULL_LSB +: 12];
         tx_faemp_out <= 12'(tx_cnt) <= tx_levels_r[ts_serial_pkg::LVL_AEMPTY_LSB +: 12];
         rx_ffull_out <= rx_full;
         rx_fafull_out <= 12'(rx_cnt) >= rx_levels_r[ts_serial_pkg::LVL_AFULL_LSB +: 12];
         rx_faemp_out <= 12'(rx_cnt) <= rx_levels_r[ts_serial_pkg::LVL_AEMPTY_LSB +: 12];
      end
   end

   // Sync detector on the comma-free byte stream.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         det_r <= ts_serial_pkg::DET_SEEK;
         sel_r <= 2'h0;
         pos_r <= 8'h00;
         slot_r <= 8'h00;
         match_r <= 8'h00;
         err_r <= 8'h00;
         hunt_r <= 8'h00;
         runt_r <= 1'b0;
         giant_r <= 1'b0;
      end else if (byte_ev) begin
         case (det_r)
            ts_serial_pkg::DET_SEEK: begin
               // Wait for the first candidate sync byte.
               if (is_sync) begin
                  det_r <= ts_serial_pkg::DET_TRACK;
                  pos_r <= 8'h01;
                  match_r <= 8'h00;
               end
            end
            ts_serial_pkg::DET_TRACK: begin
               if (pos_r != len_val) begin
                  pos_r <= pos_r + 8'h01;
               end else if (is_sync) begin
                  // Sync recurred one packet later.
                  pos_r <= 8'h01;
                  match_r <= match_r + 8'h01;
                  if (past_thr(match_r, detect_cfg_r[ts_serial_pkg::CFG_MATCH_LSB +: 8])) begin
                     det_r <= ts_serial_pkg::DET_LOCK;
                     slot_r <= 8'h01;
                     err_r <= 8'h00;
                     hunt_r <= 8'h00;
                  end
               end else begin
                  // Miss: count the failed packet and maybe try another pairing.
                  det_r <= ts_serial_pkg::DET_SEEK;
                  if (past_thr(hunt_r, detect_cfg_r[ts_serial_pkg::CFG_HUNT_LSB +: 8])) begin
                     hunt_r <= 8'h00;
                     sel_r <= sel_r + 2'h1;
                  end else begin
                     hunt_r <= hunt_r + 8'h01;
                  end
               end
            end
            ts_serial_pkg::DET_LOCK: begin
               if (is_sync) begin
                  // Packet boundary: judge the spacing from the last one.
                  pos_r <= 8'h01;
                  slot_r <= 8'h01;
                  runt_r <= pos_r < len_val;
                  giant_r <= pos_r > len_val;
                  if (pos_r == len_val) begin
                     err_r <= 8'h00;
                  end
               end else begin
                  if (pos_r != 8'hFF) begin
                     pos_r <= pos_r + 8'h01;
                  end
                  if (slot_r != len_val) begin
                     slot_r <= slot_r + 8'h01;
                  end else begin
                     // Expected sync missing; the next one is due a packet later, so a
                     // lost stream keeps counting misses until the lock drops.
                     slot_r <= 8'h01;
                     err_r <= err_r + 8'h01;
                     if (past_thr(err_r, detect_cfg_r[ts_serial_pkg::CFG_UNLOCK_LSB +: 8])) begin
                        det_r <= ts_serial_pkg::DET_SEEK;
                        runt_r <= 1'b0;
                        giant_r <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               det_r <= ts_serial_pkg::DET_SEEK;
            end
         endcase
      end
   end

   // Detector results onto the function outputs.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         rx_locked_out <= 1'b0;
         rx_sync_byte_out <= 1'b0;
         rx_pkt_size_out <= 1'b0;
         rx_runt_out <= 1'b0;
         rx_giant_out <= 1'b0;
      end else begin
         rx_locked_out <= det_r == ts_serial_pkg::DET_LOCK;
         rx_sync_byte_out <= sel_r[0];
         rx_pkt_size_out <= sel_r[1];
         rx_runt_out <= runt_r;
         rx_giant_out <= giant_r;
      end
   end

   // Avalon-MM slave: waitrequest high until the answer cycle, one cycle low.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         ack_r <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack_r <= bus_req;
         avs_waitrequest_out <= !bus_req;
         if (bus_req && avs_read_in) begin
            // Read data is ready in the cycle waitrequest is low.
            if (avs_address_in == ts_serial_pkg::OFF_STATUS) begin
               avs_readdata_out <= 32'h0000_0000;
               avs_readdata_out[ts_serial_pkg::ST_LOCKED_BIT] <= rx_locked_out;
               avs_readdata_out[ts_serial_pkg::ST_SYNC_BIT] <= rx_sync_byte_out;
               avs_readdata_out[ts_serial_pkg::ST_SIZE_BIT] <= rx_pkt_size_out;
               avs_readdata_out[ts_serial_pkg::ST_RUNT_BIT] <= rx_runt_out;
               avs_readdata_out[ts_serial_pkg::ST_GIANT_BIT] <= rx_giant_out;
               avs_readdata_out[ts_serial_pkg::ST_TX_FULL_BIT] <= tx_ffull_out;
               avs_readdata_out[ts_serial_pkg::ST_TX_AFULL_BIT] <= tx_fafull_out;
               avs_readdata_out[ts_serial_pkg::ST_TX_AEMPTY_BIT] <= tx_faemp_out;
               avs_readdata_out[ts_serial_pkg::ST_RX_FULL_BIT] <= rx_ffull_out;
               avs_readdata_out[ts_serial_pkg::ST_RX_AFULL_BIT] <= rx_fafull_out;
               avs_readdata_out[ts_serial_pkg::ST_RX_AEMPTY_BIT] <= rx_faemp_out;
            end else if (avs_address_in == ts_serial_pkg::OFF_DETECT_CFG) begin
               avs_readdata_out <= detect_cfg_r;
            end else if (avs_address_in == ts_serial_pkg::OFF_TX_LEVELS) begin
               avs_readdata_out <= tx_levels_r;
            end else if (avs_address_in == ts_serial_pkg::OFF_RX_LEVELS) begin
               avs_readdata_out <= rx_levels_r;
            end else begin
               // Unmapped offsets read as zero.
               avs_readdata_out <= 32'h0000_0000;
            end
         end
      end
   end

   // Configuration writes take effect at the edge the master sees waitrequest low.
   always_ff @(posedge clock_in or posedge kill_r) begin
      if (kill_r) begin
         detect_cfg_r <= 32'h0000_0000;
         detect_cfg_r[ts_serial_pkg::CFG_MATCH_LSB +: 8] <= ts_serial_pkg::RST_MATCH_THR;
         detect_cfg_r[ts_serial_pkg::CFG_UNLOCK_LSB +: 8] <= ts_serial_pkg::RST_UNLOCK_THR;
         detect_cfg_r[ts_serial_pkg::CFG_HUNT_LSB +: 8] <= ts_serial_pkg::RST_HUNT_THR;
         tx_levels_r <= 32'h0000_0000;
         tx_levels_r[ts_serial_pkg::LVL_AFULL_LSB +: 12] <= ts_serial_pkg::RST_AFULL_THR;
         tx_levels_r[ts_serial_pkg::LVL_AEMPTY_LSB +: 12] <= ts_serial_pkg::RST_AEMPTY_THR;
         rx_levels_r <= 32'h0000_0000;
         rx_levels_r[ts_serial_pkg::LVL_AFULL_LSB +: 12] <= ts_serial_pkg::RST_AFULL_THR;
         rx_levels_r[ts_serial_pkg::LVL_AEMPTY_LSB +: 12] <= ts_serial_pkg::RST_AEMPTY_THR;
      end else if (ack_r && avs_write_in) begin
         // Unused upper bits stay zero.
         if (avs_address_in == ts_serial_pkg::OFF_DETECT_CFG) begin
            detect_cfg_r <= merge(detect_cfg_r, avs_writedata_in, avs_byteenable_in)
                            & 32'h00FF_FFFF;
         end else if (avs_address_in == ts_serial_pkg::OFF_TX_LEVELS) begin
            tx_levels_r <= merge(tx_levels_r, avs_writedata_in, avs_byteenable_in)
                           & 32'h0FFF_0FFF;
         end else if (avs_address_in == ts_serial_pkg::OFF_RX_LEVELS) begin
            rx_levels_r <= merge(rx_levels_r, avs_writedata_in, avs_byteenable_in)
                           & 32'h0FFF_0FFF;
         end
      end
   end
endmodule

// *** rtl/ts_serial_pkg.sv ***
// Constants shared by the serial transport-stream layer 1 block.
package ts_serial_pkg;
   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_DETECT_CFG = 5'h04;
   localparam logic [4:0] OFF_TX_LEVELS = 5'h08;
   localparam logic [4:0] OFF_RX_LEVELS = 5'h0C;
   // Status register field positions.
   localparam int ST_LOCKED_BIT = 0;
   localparam int ST_SYNC_BIT = 1;
   localparam int ST_SIZE_BIT = 2;
   localparam int ST_RUNT_BIT = 3;
   localparam int ST_GIANT_BIT = 4;
   localparam int ST_TX_FULL_BIT = 8;
   localparam int ST_TX_AFULL_BIT = 9;
   localparam int ST_TX_AEMPTY_BIT = 10;
   localparam int ST_RX_FULL_BIT = 11;
   localparam int ST_RX_AFULL_BIT = 12;
   localparam int ST_RX_AEMPTY_BIT = 13;
   // Detector configuration field positions (8 bits each).
   localparam int CFG_MATCH_LSB = 0;
   localparam int CFG_UNLOCK_LSB = 8;
   localparam int CFG_HUNT_LSB = 16;
   // Level register field positions (12 bits each).
   localparam int LVL_AFULL_LSB = 0;
   localparam int LVL_AEMPTY_LSB = 16;
   // Reset values of the writable fields.
   localparam logic [7:0] RST_MATCH_THR = 8'h03;
   localparam logic [7:0] RST_UNLOCK_THR = 8'h03;
   localparam logic [7:0] RST_HUNT_THR = 8'h0C;
   localparam logic [11:0] RST_AFULL_THR = 12'h0F2;
   localparam logic [11:0] RST_AEMPTY_THR = 12'h010;
   // Stream characters and packet lengths.
   localparam logic [7:0] COMMA_CHAR = 8'hBC;
   localparam logic [7:0] SYNC_NORMAL = 8'h47;
   localparam logic [7:0] SYNC_INVERTED = 8'hB8;
   localparam logic [7:0] LEN_SHORT = 8'hBC;
   localparam logic [7:0] LEN_LONG = 8'hCC;
   // Commas placed before every packet start.
   localparam logic [1:0] LEAD_COMMAS = 2'h2;
   // Detector states.
   typedef enum logic [1:0] {DET_SEEK, DET_TRACK, DET_LOCK} det_state_e;
endpackage

// *** tb/ts_serial_layer1_checker.sv ***
// Port checks for the serial transport-stream layer 1 block.
`timescale 1ns/10ps
module ts_serial_layer1_checker (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic clear_n_in,
   input wire logic freeze_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic [7:0] txdata_out,
   input wire logic tx_k_out,
   input wire logic [7:0] rx_dout_out,
   input wire logic rx_dvalid_out,
   input wire logic rx_psync_out,
   input wire logic rx_sync_byte_out,
   input wire logic rx_locked_out,
   input wire logic rx_runt_out,
   input wire logic rx_giant_out,
   input wire logic tx_ffull_out,
   input wire logic tx_fafull_out,
   input wire logic tx_faemp_out,
   input wire logic rx_ffull_out,
   input wire logic rx_fafull_out
);
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (rst_in || !clear_n_in);
   // A bus request is answered in the next cycle, and for one cycle only.
   sequence bus_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence bus_ack;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   a_bus_answer: assert property (bus_req |=> bus_ack) else $error("bus answer");
   a_k_on_comma: assert property (
      tx_k_out |-> txdata_out == ts_serial_pkg::COMMA_CHAR) else $error("k flag");
   a_start_is_sync: assert property (
      rx_psync_out |-> rx_dvalid_out && rx_locked_out && rx_dout_out ==
      (rx_sync_byte_out ? ts_serial_pkg::SYNC_INVERTED : ts_serial_pkg::SYNC_NORMAL))
      else $error("start byte");
   a_runt_not_giant: assert property (!(rx_runt_out && rx_giant_out))
      else $error("runt and giant");
   a_flag_in_lock: assert property ($rose(rx_runt_out) || $rose(rx_giant_out)
      |-> rx_locked_out) else $error("flag unlocked");
   a_tx_full_warn: assert property (tx_ffull_out |-> tx_fafull_out && !tx_faemp_out)
      else $error("tx flags");
   a_rx_full_warn: assert property (rx_ffull_out |-> rx_fafull_out)
      else $error("rx flags");
   a_freeze_hold: assert property (freeze_in [*5] |-> $stable(txdata_out) &&
      $stable(rx_locked_out)) else $error("freeze");
endmodule
bind ts_serial_layer1 ts_serial_layer1_checker ts_serial_layer1_checker_inst (.*);

// *** tb/ts_serial_layer1_tb.sv ***
// Self-checking bench for the serial transport-stream layer 1 block.
`timescale 1ns/10ps
module ts_serial_layer1_tb;
   // Signals carry the port names, so the instance connects by name.
   logic clock_in = 1'b0, rst_in = 1'b1, clear_n_in = 1'b1, freeze_in = 1'b0;
   logic tx_clk_in = 1'b0, rx_clk_in = 1'b0, tx_psync_in = 1'b0, tx_dvalid_in = 1'b0;
   logic avs_read_in = 1'b0, avs_write_in = 1'b0, tx_full_clk_in, rx_k_in, tx_k_out;
   logic [7:0] tx_din_in = 8'h00, rxdata_in, txdata_out, rx_dout_out;
   logic [4:0] avs_address_in = 5'h00;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
   logic tx_ffull_out, tx_fafull_out, tx_faemp_out, rx_dvalid_out, rx_psync_out, rx_ffull_out;
   logic rx_fafull_out, rx_faemp_out, rx_sync_byte_out, rx_pkt_size_out, rx_locked_out;
   logic rx_runt_out, rx_giant_out, avs_waitrequest_out;
   // Model state: accepted bytes in order, comma history and flag rises.
   logic [31:0] lfsr_r = 32'hBC043529;
   logic [7:0] sent_q[$];
   logic [1:0] k_hist = 2'h0, flag_d = 2'h0;
   int err_count = 0, compares = 0, runts = 0, giants = 0;
   wire rx_full_clk_in = tx_full_clk_in;
   ts_serial_layer1 ts_serial_layer1_inst (.*);
   ts_serial_partner ts_serial_partner_inst (.clk_out(tx_full_clk_in), .txdata_in(txdata_out),
      .tx_k_in(tx_k_out), .rxdata_out(rxdata_in), .rx_k_out(rx_k_in));
   always #20 clock_in = ~clock_in;
   // User clocks are offset so that no edge meets a system clock edge.
   initial #7 forever #160 tx_clk_in = ~tx_clk_in;
   initial #11 forever #140 rx_clk_in = ~rx_clk_in;
   function automatic logic [31:0] lfsr_step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One bus transfer, held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge clock_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (n >= 20) begin
         err_count++;
         end_of_test;
      end
   endtask
   // One user transmit clock period; only valid bytes while not full go on.
   task automatic send(input logic [7:0] b, input logic s, input logic v);
      @(negedge tx_clk_in);
      @(posedge clock_in);
      tx_din_in <= b;
      tx_psync_in <= s;
      tx_dvalid_in <= v;
      if (v && tx_ffull_out === 1'b0)
         sent_q.push_back(b);
   endtask
   // A packet: flagged sync, then random payload with invalid gaps.
   task automatic packet(input int len);
      logic [7:0] d;
      send(ts_serial_pkg::SYNC_NORMAL, 1'b1, 1'b1);
      for (int i = 1; i < len; i++) begin
         lfsr_r = lfsr_step(lfsr_r);
         d = lfsr_r[7:0];
         // Gaps are rare, so a backlog builds and lead commas meet waiting payload.
         if (lfsr_r[15:8] == 8'h00)
            send(~d, 1'b0, 1'b0);
         if (d == ts_serial_pkg::SYNC_NORMAL || d == ts_serial_pkg::SYNC_INVERTED)
            d = 8'h00;
         send(d, 1'b0, 1'b1);
      end
   endtask
   // A start byte on the line follows two flagged commas.
   always @(posedge tx_full_clk_in) begin
      if (tx_k_out === 1'b0 && txdata_out === ts_serial_pkg::SYNC_NORMAL)
         check(k_hist, 2'h3);
      k_hist <= {k_hist[0], tx_k_out};
   end
   // Each delivered byte is the next accepted one; none comes when all are out.
   always @(posedge rx_clk_in)
      if (rx_dvalid_out === 1'b1)
         check(rx_dout_out, sent_q.size() > 0 ? sent_q.pop_front() : 9'h100);
   // Rises of the runt and giant reports are counted.
   always @(posedge clock_in) begin
      flag_d <= {rx_giant_out, rx_runt_out};
      runts += int'(rx_runt_out === 1'b1 && flag_d[0] !== 1'b1);
      giants += int'(rx_giant_out === 1'b1 && flag_d[1] !== 1'b1);
   end
   initial begin
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      bus(1'b0, ts_serial_pkg::OFF_STATUS, 32'h0);
      check(q, 32'h00002400);
      bus(1'b1, ts_serial_pkg::OFF_DETECT_CFG, 32'hFF200303);
      bus(1'b0, ts_serial_pkg::OFF_DETECT_CFG, 32'h0);
      check(q, 32'h00200303);
      bus(1'b0, 5'h10, 32'h0);
      check(q, 32'h0);
      repeat (7) packet(188);
      packet(100);
      packet(188);
      packet(250);
      repeat (2) packet(188);
      send(8'h00, 1'b0, 1'b0);
      for (int i = 0; i < 3000 && sent_q.size() > 0; i++)
         @(posedge clock_in);
      repeat (20) @(posedge clock_in);
      check(sent_q.size(), 0);
      check(runts, 1);
      check(giants, 1);
      bus(1'b0, ts_serial_pkg::OFF_STATUS, 32'h0);
      check(q[4:0], 5'h01);
      // A long run with no sync byte: four missed slots must drop the lock.
      repeat (800) send(8'h00, 1'b0, 1'b1);
      send(8'h00, 1'b0, 1'b0);
      for (int i = 0; i < 3000 && sent_q.size() > 0; i++)
         @(posedge clock_in);
      repeat (20) @(posedge clock_in);
      check(sent_q.size(), 0);
      bus(1'b0, ts_serial_pkg::OFF_STATUS, 32'h0);
      check(q[4:0], 5'h00);
      freeze_in <= 1'b1;
      repeat (40) @(posedge clock_in);
      freeze_in <= 1'b0;
      clear_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      check({rx_locked_out, tx_k_out, tx_faemp_out}, 3'h3);
      clear_n_in <= 1'b1;
      end_of_test;
   end
endmodule

// *** tb/ts_serial_partner.sv ***
// Serializer model: free byte clock and loopback of the line.
`timescale 1ns/10ps
module ts_serial_partner (
   output logic clk_out,
   input wire logic [7:0] txdata_in,
   input wire logic tx_k_in,
   output logic [7:0] rxdata_out,
   output logic rx_k_out
);
   // The line byte clock runs free, with a phase of its own.
   initial begin
      clk_out = 1'b0;
      #13;
      forever #160 clk_out = ~clk_out;
   end
   // Each byte is looped back with its comma flag and held a byte period.
   always @(posedge clk_out) begin
      rxdata_out <= txdata_in;
      rx_k_out <= tx_k_in;
   end
endmodule
